// [core/bsfct_pkg.sv]
// Constants and types for the boot serial flash command tail
package bsfct_pkg;

  localparam logic [7:0]  CMD_DUMP    = 8'hFC;
  localparam logic [7:0]  CMD_CHECK   = 8'hFD;
  localparam logic [7:0]  CMD_PROG    = 8'h41;
  localparam logic [7:0]  CMD_IDCHK   = 8'hF5;
  localparam logic [7:0]  CMD_BAUD_LO = 8'hB0;
  localparam logic [7:0]  CMD_BAUD_HI = 8'hB4;

  localparam int          PAGE_BYTES  = 256;
  localparam logic [8:0]  PAGE_LAST   = 9'h0FF;
  localparam logic [1:0]  ID_HDR_LAST = 2'h3;
  localparam int          ID_LEN      = 6;
  localparam logic [7:0]  ID_LEN_B    = 8'h06;
  // Stored ID byte addresses, first byte in the low slice
  localparam logic [ID_LEN*24-1:0] ID_ADDRS = {
    24'h0FFFFB, 24'h0FFFF7, 24'h0FFFEF,
    24'h0FFFEB, 24'h0FFFE3, 24'h0FFFDF};

  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_INIT    = 16'h0000;

  localparam int          FIFO_WIDTH  = 8;
  localparam int          FIFO_DEPTH  = 8;

  typedef enum logic [2:0] {
    BAUD_9600, BAUD_19200, BAUD_38400, BAUD_57600, BAUD_115200
  } bsfct_baud_t;

  localparam bsfct_baud_t BAUD_RESET  = BAUD_9600;

  typedef struct packed {
    logic        en;
    logic        boot;
    logic [23:0] addr;
  } bsfct_rd_req_t;

endpackage

// [core/bsfct_fifo.sv]
// Byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module bsfct_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("bsfct_fifo: DEPTH must be >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // bsfct_fifo

`default_nettype wire

// [core/bsfct_core.sv]
// Boot serial flash command tail: dump, check value, baud, ID gate
`timescale 1ns/1ps
`default_nettype none

module bsfct_core #(
  parameter int FIFO_DEPTH = bsfct_pkg::FIFO_DEPTH
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_data,
  input  wire logic                  flash_blank,
  output bsfct_pkg::bsfct_rd_req_t   rd_req,
  input  wire logic [7:0]            rd_data,
  output logic                       tx_valid,
  output logic [7:0]                 tx_data,
  input  wire logic                  tx_ready,
  input  wire logic                  tx_busy,
  output bsfct_pkg::bsfct_baud_t     baud_sel,
  output logic                       id_ok,
  output logic                       cmd_refused
);

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR_LO, S_ADDR_HI, S_DUMP_RD, S_DUMP_LAT, S_DUMP_WR,
    S_PROG, S_CRC_LO, S_CRC_HI, S_ECHO, S_BAUD_WAIT,
    S_ID_HDR, S_ID_DATA, S_ID_RD, S_ID_CMP
  } bsfct_state_t;

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("bsfct_core: FIFO_DEPTH must be at least 2");
  end

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ bsfct_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  bsfct_state_t           state_q,    state_d;
  logic [7:0]             cmd_q,      cmd_d;
  logic [15:0]            addr_q,     addr_d;
  logic [8:0]             idx_q,      idx_d;
  logic [15:0]            crc_q,      crc_d;
  logic [15:0]            hold_q,     hold_d;
  logic [7:0]             data_q,     data_d;
  logic [7:0]             byte_q,     byte_d;
  logic [7:0]             cnt_q,      cnt_d;
  logic                   match_q,    match_d;
  logic                   idok_q,     idok_d;
  logic                   refused_q,  refused_d;
  bsfct_pkg::bsfct_baud_t baud_q,     baud_d;
  bsfct_pkg::bsfct_rd_req_t req;

  logic                   push;
  logic [7:0]             push_data;
  logic                   fifo_ready;
  logic                   fifo_valid;

  // Gate: blank flash or matched ID lets commands through
  wire locked   = !flash_blank && !idok_q;
  wire is_baud  = (rx_data >= bsfct_pkg::CMD_BAUD_LO) &&
                  (rx_data <= bsfct_pkg::CMD_BAUD_HI);
  wire id_in    = (idx_q < 9'(bsfct_pkg::ID_LEN));
  wire [23:0] id_addr = id_in ?
    bsfct_pkg::ID_ADDRS[idx_q[2:0]*24 +: 24] : 24'h000000;
  wire id_eq    = id_in && (byte_q == rd_data);
  wire last_id  = ((idx_q + 9'h001) == {1'b0, cnt_q});
  wire [2:0] baud_code = cmd_q[2:0] - bsfct_pkg::CMD_BAUD_LO[2:0];

  always_comb begin
    state_d   = state_q;
    cmd_d     = cmd_q;
    addr_d    = addr_q;
    idx_d     = idx_q;
    crc_d     = crc_q;
    hold_d    = hold_q;
    data_d    = data_q;
    byte_d    = byte_q;
    cnt_d     = cnt_q;
    match_d   = match_q;
    idok_d    = idok_q;
    baud_d    = baud_q;
    refused_d = 1'b0;
    push      = 1'b0;
    push_data = 8'h00;
    req       = '0;
    case (state_q)
      S_IDLE: begin
        if (rx_valid) begin
          cmd_d = rx_data;
          idx_d = 9'h000;
          if (locked && rx_data != bsfct_pkg::CMD_IDCHK) begin
            refused_d = 1'b1;
          end else if (rx_data == bsfct_pkg::CMD_DUMP ||
                       rx_data == bsfct_pkg::CMD_PROG) begin
            state_d = S_ADDR_LO;
          end else if (rx_data == bsfct_pkg::CMD_CHECK) begin
            hold_d  = crc_q;
            crc_d   = bsfct_pkg::CRC_INIT;
            state_d = S_CRC_LO;
          end else if (is_baud) begin
            state_d = S_ECHO;
          end else if (rx_data == bsfct_pkg::CMD_IDCHK) begin
            state_d = S_ID_HDR;
          end
        end
      end
      S_ADDR_LO: begin
        if (rx_valid) begin
          addr_d[7:0] = rx_data;
          state_d     = S_ADDR_HI;
        end
      end
      S_ADDR_HI: begin
        if (rx_valid) begin
          addr_d[15:8] = rx_data;
          state_d = (cmd_q == bsfct_pkg::CMD_PROG) ? S_PROG : S_DUMP_RD;
        end
      end
      S_DUMP_RD: begin
        req.en   = 1'b1;
        req.boot = 1'b1;
        req.addr = {addr_q, idx_q[7:0]};
        state_d  = S_DUMP_LAT;
      end
      S_DUMP_LAT: begin
        data_d  = rd_data;
        state_d = S_DUMP_WR;
      end
      S_DUMP_WR: begin
        push      = 1'b1;
        push_data = data_q;
        if (fifo_ready) begin
          if (idx_q == bsfct_pkg::PAGE_LAST) begin
            state_d = S_IDLE;
          end else begin
            idx_d   = idx_q + 9'h001;
            state_d = S_DUMP_RD;
          end
        end
      end
      S_PROG: begin
        if (rx_valid) begin
          crc_d = crc_step(crc_q, rx_data);
          if (idx_q == bsfct_pkg::PAGE_LAST) begin
            state_d = S_IDLE;
          end else begin
            idx_d = idx_q + 9'h001;
          end
        end
      end
      S_CRC_LO: begin
        push      = 1'b1;
        push_data = hold_q[7:0];
        if (fifo_ready) begin
          state_d = S_CRC_HI;
        end
      end
      S_CRC_HI: begin
        push      = 1'b1;
        push_data = hold_q[15:8];
        if (fifo_ready) begin
          state_d = S_IDLE;
        end
      end
      S_ECHO: begin
        push      = 1'b1;
        push_data = cmd_q;
        if (fifo_ready) begin
          state_d = S_BAUD_WAIT;
        end
      end
      S_BAUD_WAIT: begin
        if (!fifo_valid && !tx_busy) begin
          baud_d  = bsfct_pkg::bsfct_baud_t'(baud_code);
          state_d = S_IDLE;
        end
      end
      S_ID_HDR: begin
        if (rx_valid) begin
          idx_d = idx_q + 9'h001;
          if (idx_q[1:0] == bsfct_pkg::ID_HDR_LAST) begin
            cnt_d   = rx_data;
            match_d = (rx_data == bsfct_pkg::ID_LEN_B);
            idx_d   = 9'h000;
            if (rx_data == 8'h00) begin
              idok_d  = 1'b0;
              state_d = S_IDLE;
            end else begin
              state_d = S_ID_DATA;
            end
          end
        end
      end
      S_ID_DATA: begin
        if (rx_valid) begin
          byte_d  = rx_data;
          state_d = S_ID_RD;
        end
      end
      S_ID_RD: begin
        req.en   = 1'b1;
        req.addr = id_addr;
        state_d  = S_ID_CMP;
      end
      S_ID_CMP: begin
        match_d = match_q && id_eq;
        if (last_id) begin
          idok_d  = match_q && id_eq;
          state_d = S_IDLE;
        end else begin
          idx_d   = idx_q + 9'h001;
          state_d = S_ID_DATA;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= S_IDLE;
      cmd_q     <= 8'h00;
      addr_q    <= 16'h0000;
      idx_q     <= 9'h000;
      crc_q     <= bsfct_pkg::CRC_INIT;
      hold_q    <= 16'h0000;
      data_q    <= 8'h00;
      byte_q    <= 8'h00;
      cnt_q     <= 8'h00;
      match_q   <= 1'b0;
      idok_q    <= 1'b0;
      refused_q <= 1'b0;
      baud_q    <= bsfct_pkg::BAUD_RESET;
    end else begin
      state_q   <= state_d;
      cmd_q     <= cmd_d;
      addr_q    <= addr_d;
      idx_q     <= idx_d;
      crc_q     <= crc_d;
      hold_q    <= hold_d;
      data_q    <= data_d;
      byte_q    <= byte_d;
      cnt_q     <= cnt_d;
      match_q   <= match_d;
      idok_q    <= idok_d;
      refused_q <= refused_d;
      baud_q    <= baud_d;
    end
  end

  // Transmit bytes queue here; a stalled UART stalls the command engine
  bsfct_fifo #(
    .WIDTH (bsfct_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  assign tx_valid    = fifo_valid;
  assign rd_req      = req;
  assign baud_sel    = baud_q;
  assign id_ok       = idok_q;
  assign cmd_refused = refused_q;

endmodule // bsfct_core

`default_nettype wire

// [dv/bsfct_props.sv]
// Checker for the boot serial flash command tail
`timescale 1ns/1ps
`default_nettype none
module bsfct_props (
  input wire logic                     clk,
  input wire logic                     reset_n,
  input wire logic                     rx_valid,
  input wire logic [7:0]               rx_data,
  input wire logic                     flash_blank,
  input wire bsfct_pkg::bsfct_rd_req_t rd_req,
  input wire logic [7:0]               rd_data,
  input wire logic                     tx_valid,
  input wire logic [7:0]               tx_data,
  input wire logic                     tx_ready,
  input wire logic                     tx_busy,
  input wire bsfct_pkg::bsfct_baud_t   baud_sel,
  input wire logic                     id_ok,
  input wire logic                     cmd_refused
);
  logic [23:0] last_q;
  logic        lv_q;
  logic [7:0]  pop_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lv_q   <= 1'b0;
      last_q <= 24'h000000;
      pop_q  <= 8'h00;
    end else begin
      if (rd_req.en && rd_req.boot) begin
        lv_q   <= 1'b1;
        last_q <= rd_req.addr;
      end
      if (tx_valid && tx_ready) begin
        pop_q <= tx_data;
      end
    end
  end
  sequence s_boot_rd;
    rd_req.en && rd_req.boot;
  endsequence
  a_refuse_locked: assert property (cmd_refused |-> $past(rx_valid) &&
    !$past(flash_blank) && !$past(id_ok) &&
    $past(rx_data) != bsfct_pkg::CMD_IDCHK)
    else $error("refusal without locked cause");
  a_refuse_pulse: assert property (cmd_refused |=> !cmd_refused)
    else $error("refusal longer than one cycle");
  a_page_order: assert property (s_boot_rd |->
    ((lv_q && last_q[7:0] != 8'hFF) ? rd_req.addr == last_q + 24'h1
                                   : rd_req.addr[7:0] == 8'h00))
    else $error("boot page read out of order");
  a_id_addr: assert property (rd_req.en && !rd_req.boot |->
    rd_req.addr inside {24'h0FFFDF, 24'h0FFFE3, 24'h0FFFEB,
                        24'h0FFFEF, 24'h0FFFF7, 24'h0FFFFB})
    else $error("stored id read at wrong address");
  a_rd_pulse: assert property (rd_req.en |=> !rd_req.en)
    else $error("read request longer than one cycle");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data))
    else $error("tx byte dropped while stalled");
  a_baud_drain: assert property ($changed(baud_sel) |->
    $past(!tx_valid && !tx_busy))
    else $error("rate changed before echo finished");
  a_baud_code: assert property ($changed(baud_sel) |->
    pop_q == bsfct_pkg::CMD_BAUD_LO + 8'(baud_sel))
    else $error("rate does not match echoed code");
endmodule // bsfct_props
bind bsfct_core bsfct_props u_props (.clk(clk), .reset_n(reset_n),
  .rx_valid(rx_valid), .rx_data(rx_data), .flash_blank(flash_blank),
  .rd_req(rd_req), .rd_data(rd_data), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .tx_busy(tx_busy),
  .baud_sel(baud_sel), .id_ok(id_ok), .cmd_refused(cmd_refused));
`default_nettype wire

// [dv/bsfct_host_model.sv]
// UART side and flash read model facing the command tail
`timescale 1ns/1ps
`default_nettype none
module bsfct_host_model (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     slow,
  input  wire bsfct_pkg::bsfct_rd_req_t rd_req,
  output logic [7:0]                    rd_data,
  input  wire logic                     tx_valid,
  output logic                          tx_ready,
  output logic                          tx_busy
);
  logic [3:0] busy_q;
  assign tx_busy  = busy_q != 4'h0;
  assign tx_ready = !tx_busy;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q  <= 4'h0;
      rd_data <= 8'h00;
    end else begin
      // Answer one cycle after a read, else a changing pattern
      rd_data <= rd_req.en ? rd_req.addr[7:0] ^ rd_req.addr[15:8] ^
                 rd_req.addr[23:16] : ~rd_data;
      if (tx_valid && tx_ready) begin
        busy_q <= slow ? 4'hC : 4'h2;
      end else if (tx_busy) begin
        busy_q <= busy_q - 4'h1;
      end
    end
  end
endmodule // bsfct_host_model
`default_nettype wire

// [dv/bsfct_core_tb.sv]
// Self-checking bench for the boot serial flash command tail
`timescale 1ns/1ps
`default_nettype none
module bsfct_core_tb;
  logic clk, reset_n, rx_valid, flash_blank, slow, tx_valid, tx_ready;
  logic tx_busy, id_ok, cmd_refused;
  logic [7:0] rx_data, rd_data, tx_data, d8;
  logic [15:0] crc, pg;
  logic [7:0] q[$];
  bsfct_pkg::bsfct_rd_req_t rd_req;
  bsfct_pkg::bsfct_baud_t   baud_sel;
  integer seed, n_mismatch, checks, nref, i;
  bsfct_core dut (.clk(clk), .reset_n(reset_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .flash_blank(flash_blank), .rd_req(rd_req),
    .rd_data(rd_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .tx_busy(tx_busy), .baud_sel(baud_sel),
    .id_ok(id_ok), .cmd_refused(cmd_refused));
  bsfct_host_model u_host (.clk(clk), .reset_n(reset_n), .slow(slow),
    .rd_req(rd_req), .rd_data(rd_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_busy(tx_busy));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) q.push_back(tx_data);
    if (cmd_refused === 1'b1) nref = nref + 1;
  end
  function automatic logic [7:0] fdat(logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16];
  endfunction
  function automatic logic [15:0] crc8(logic [15:0] c, logic [7:0] d);
    for (int k = 7; k >= 0; k--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? bsfct_pkg::CRC_POLY : 16'h0);
    end
    return c;
  endfunction
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic snd(logic [7:0] b);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data  = b;
    @(negedge clk);
    rx_valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic getn(int n);
    for (int k = 0; k < 20000 && q.size() < n; k++) @(negedge clk);
    if (q.size() < n) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  endtask
  task automatic idseq(logic bad);
    snd(bsfct_pkg::CMD_IDCHK);
    for (int k = 0; k < 3; k++) snd(bsfct_pkg::ID_ADDRS[k*8 +: 8]);
    snd(bsfct_pkg::ID_LEN_B);
    for (int k = 0; k < 6; k++) begin
      snd(fdat(bsfct_pkg::ID_ADDRS[k*24 +: 24]) ^ {7'h00, bad && k == 5});
    end
    repeat (4) @(negedge clk);
  endtask
  initial begin
    seed = 3;
    n_mismatch = 0;
    checks = 0;
    nref = 0;
    reset_n = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    flash_blank = 1'b0;
    slow = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    chk("baud_sel", 16'(baud_sel), 16'h0000);
    snd(bsfct_pkg::CMD_DUMP);
    chk("refused", nref[15:0], 16'h0001);
    idseq(1'b1);
    chk("id_ok", 16'(id_ok), 16'h0000);
    idseq(1'b0);
    chk("id_ok", 16'(id_ok), 16'h0001);
    slow = 1'b1;
    pg = 16'($random(seed));
    snd(bsfct_pkg::CMD_DUMP);
    snd(pg[7:0]);
    snd(pg[15:8]);
    getn(256);
    for (i = 0; i < 256; i++) begin
      chk("dump", {8'h00, q[i]}, {8'h00, fdat({pg, i[7:0]})});
    end
    slow = 1'b0;
    snd(bsfct_pkg::CMD_CHECK);
    getn(258);
    chk("check", {q[257], q[256]}, bsfct_pkg::CRC_INIT);
    q.delete();
    crc = bsfct_pkg::CRC_INIT;
    snd(bsfct_pkg::CMD_PROG);
    snd(pg[7:0]);
    snd(pg[15:8]);
    for (i = 0; i < 256; i++) begin
      d8 = 8'($random(seed));
      crc = crc8(crc, d8);
      snd(d8);
    end
    snd(bsfct_pkg::CMD_CHECK);
    getn(2);
    chk("check", {q[1], q[0]}, crc);
    snd(bsfct_pkg::CMD_CHECK);
    getn(4);
    chk("check", {q[3], q[2]}, 16'h0000);
    idseq(1'b1);
    chk("id_ok", 16'(id_ok), 16'h0000);
    flash_blank = 1'b1;
    slow = 1'b1;
    for (i = 1; i < 6; i++) begin
      q.delete();
      snd(bsfct_pkg::CMD_BAUD_LO + 8'(i % 5));
      getn(1);
      chk("echo", {8'h00, q[0]}, 16'(bsfct_pkg::CMD_BAUD_LO + i % 5));
      chk("baud_sel", 16'(baud_sel), 16'((i - 1) % 5));
      for (int k = 0; k < 100 && baud_sel !== i % 5; k++) @(negedge clk);
      chk("baud_sel", 16'(baud_sel), 16'(i % 5));
    end
    chk("refused", nref[15:0], 16'h0001);
    end_of_test();
  end
endmodule // bsfct_core_tb
`default_nettype wire
